// File: rtl/hsm_pkg.sv
// Constants, register map and shared types of the homing search and input mode block.
// Functional notes
// - Input mode 0 maps inputs one to three to home, left end, right end switch.
// - Input mode 1 keeps home on input one; inputs two, three become encoder A, B.
// - Input mode 2 frees all inputs: input one analog, inputs two, three digital.
// - Reference search may start only while input mode selects reference switches.
// - Inputs read through digital bank; analog input one in free mode reads through analog bank.
// - Search is a state machine started and stopped by opcode 13 commands and polled through the status register.
// - End-switch automatic stop enables have no effect while a search runs.
// - Until the switch is first found, motion uses the search speed.
// - Creep off switch, re-enter opposite way, zero at midpoint, all at calibration speed.
// - Search mode comes from the mode setting; mode 1 searches left switch only.
// - Modes 1 to 4 plus 64 exchange left and right switch roles.
// - Mode 2 finds right then left switch, zeroes left, stores switch distance.
// - Mode 3 finds right, centres on left switch, stores right-to-middle distance.
// - Mode 4 approaches left switch from both sides and zeroes at its middle.
// - Mode 5 seeks home negative, reversing at the left limit.
// - Mode 6 seeks home positive, reversing at the right limit.
// - Mode 7 seeks home positive, mode 8 negative, both ignoring end switches.
// - Home modes plus 128 invert home switch polarity.
// - 256 signed 32-bit user variables; only first 56 can be stored nonvolatile.
// - After boot, stored values are copied back into the volatile variables.
// - Read, set, arithmetic, store and restore commands act on user variables.
package hsm_pkg;
    localparam int SPEED_W = 24;
    localparam int AIN_W = 10;
    localparam int UV_COUNT = 256;
    localparam int UV_NV_COUNT = 56;
    localparam logic [7:0] UV_NV_LAST = 8'h37;

    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_SMODE = 8'h04;
    localparam logic [7:0] A_SSPEED = 8'h08;
    localparam logic [7:0] A_CSPEED = 8'h0C;
    localparam logic [7:0] A_DIST = 8'h10;
    localparam logic [7:0] A_POS = 8'h14;
    localparam logic [7:0] A_CMD = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1C;
    localparam logic [7:0] A_DIN = 8'h20;
    localparam logic [7:0] A_AIN = 8'h24;
    localparam logic [7:0] A_VCMD = 8'h28;
    localparam logic [7:0] A_VARG = 8'h2C;
    localparam logic [7:0] A_VRD = 8'h30;

    localparam logic [1:0] IMODE_REF = 2'h0;
    localparam logic [1:0] IMODE_ENC = 2'h1;
    localparam logic [1:0] IMODE_FREE = 2'h2;
    localparam logic [7:0] OPC_REF_SEARCH = 8'h0D;
    localparam logic [7:0] RFS_START = 8'h00;
    localparam logic [7:0] RFS_STOP = 8'h01;
    localparam int MODE_SWAP_BIT = 6;
    localparam int MODE_INV_BIT = 7;

    localparam logic [3:0] CFG_RST = 4'h0;
    localparam logic [7:0] SMODE_RST = 8'h01;
    localparam logic [SPEED_W-1:0] SSPEED_RST = 24'h00_C800;
    localparam logic [SPEED_W-1:0] CSPEED_RST = 24'h00_1900;

    typedef enum logic [2:0] {
        VOP_READ = 3'h0, VOP_SET = 3'h1, VOP_ADD = 3'h2, VOP_SUB = 3'h3, VOP_STORE = 3'h4, VOP_RESTORE = 3'h5
    } hsm_vop_t;

    typedef struct packed {
        logic home;
        logic left;
        logic right;
    } hsm_sw_t;

    typedef struct packed {
        logic valid;
        logic far_first;
        logic middle;
        logic [1:0] sw_sel;
        logic pos_dir;
        logic [1:0] rev_lim;
        logic home_inv;
    } hsm_plan_t;

    localparam logic [1:0] SEL_HOME = 2'h0;
    localparam logic [1:0] SEL_LEFT = 2'h1;
    localparam logic [1:0] SEL_RIGHT = 2'h2;
endpackage : hsm_pkg

// File: rtl/hsm_homing.sv
// Homing search state machine, input mode mapping and user variable store behind APB.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module hsm_homing
    import hsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic general_input_one,
    input wire logic general_input_two,
    input wire logic general_input_three,
    input wire logic [AIN_W-1:0] ain_value,
    input wire logic step_tick,
    output logic enc_a,
    output logic enc_b,
    output logic [SPEED_W-1:0] vel_out,
    output logic dir_out,
    output logic end_stop,
    output logic search_busy
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001, S_FAR = 7'b000_0010, S_SEEK = 7'b000_0100, S_CLEAR = 7'b000_1000,
        S_ENTER = 7'b001_0000, S_THRU = 7'b010_0000, S_DONE = 7'b100_0000
    } hsm_state_t;

    function automatic hsm_plan_t decode_mode(input logic [7:0] m);
        hsm_plan_t p;
        logic [5:0] b;
        p = '0;
        b = m[5:0];
        if (b >= 6'h01 && b <= 6'h04 && !m[MODE_INV_BIT]) begin
            p.valid = 1'b1;
            p.far_first = (b == 6'h02) || (b == 6'h03);
            p.middle = (b == 6'h03) || (b == 6'h04);
            p.sw_sel = m[MODE_SWAP_BIT] ? SEL_RIGHT : SEL_LEFT;
            p.pos_dir = m[MODE_SWAP_BIT];
        end else if (b >= 6'h05 && b <= 6'h08 && !m[MODE_SWAP_BIT]) begin
            p.valid = 1'b1;
            p.middle = 1'b1;
            p.sw_sel = SEL_HOME;
            p.pos_dir = (b == 6'h06) || (b == 6'h07);
            p.rev_lim = (b == 6'h05) ? SEL_LEFT : (b == 6'h06) ? SEL_RIGHT : 2'h0;
            p.home_inv = m[MODE_INV_BIT];
        end
        return p;
    endfunction : decode_mode

    function automatic logic pick_sw(input hsm_sw_t s, input logic [1:0] sel, input logic inv);
        return (sel == SEL_HOME) ? (s.home ^ inv) : (sel == SEL_LEFT) ? s.left : s.right;
    endfunction : pick_sw

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] imode_reg;
    logic stop_left_en_reg, stop_right_en_reg;
    logic [7:0] smode_reg;
    logic [SPEED_W-1:0] sspeed_reg, cspeed_reg;
    logic [31:0] dist_reg, pos_reg, varg_reg, vrd_reg;
    logic refused_reg, var_err_reg;
    logic [31:0] uv_ram [UV_COUNT];
    logic [31:0] uv_nv [UV_NV_COUNT];
    logic boot_busy_reg;
    logic [7:0] boot_idx_reg;
    hsm_state_t state_reg, state_next;
    hsm_plan_t plan_reg;
    logic run_dir_reg, run_dir_next;
    logic [31:0] far_pos_reg, e1_reg, e2_reg, e3_reg, ref_pos;
    hsm_sw_t sw;
    hsm_plan_t smode_plan;

    assign smode_plan = decode_mode(smode_reg);
    wire wr_en = psel && penable && pwrite;
    wire cmd_wr = wr_en && paddr == A_CMD && pwdata[7:0] == OPC_REF_SEARCH;
    wire start_cmd = cmd_wr && pwdata[15:8] == RFS_START;
    wire stop_cmd = cmd_wr && pwdata[15:8] == RFS_STOP;
    wire start_ok = start_cmd && imode_reg == IMODE_REF && smode_plan.valid;
    wire vcmd_wr = wr_en && paddr == A_VCMD && !boot_busy_reg;
    wire [7:0] vidx = pwdata[7:0];
    wire [2:0] vop = pwdata[10:8];

    ////////////////////////////////////////////////////////////////////////////////
    // All switch roles exist in reference mode; encoder mode keeps only home, free mode leaves them inactive.
    always_comb begin
        sw = '0;
        if (imode_reg == IMODE_REF) begin
            sw = '{home: general_input_one, left: general_input_two, right: general_input_three};
        end else if (imode_reg == IMODE_ENC) begin
            sw.home = general_input_one;
        end
    end
    assign enc_a = (imode_reg == IMODE_ENC) && general_input_two;
    assign enc_b = (imode_reg == IMODE_ENC) && general_input_three;
    assign pready = 1'b1;
    assign search_busy = state_reg != S_IDLE;

    // Automatic end stops are suppressed during a search so the switches can be driven into.
    assign end_stop = !search_busy && ((stop_left_en_reg && sw.left) || (stop_right_en_reg && sw.right));

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imode_reg <= IMODE_REF;
            {stop_right_en_reg, stop_left_en_reg} <= 2'h0;
            smode_reg <= SMODE_RST;
            sspeed_reg <= SSPEED_RST;
            cspeed_reg <= CSPEED_RST;
            varg_reg <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (paddr)
                A_CFG: {stop_right_en_reg, stop_left_en_reg, imode_reg} <= pwdata[3:0];
                A_SMODE: smode_reg <= pwdata[7:0];
                A_SSPEED: sspeed_reg <= pwdata[SPEED_W-1:0];
                A_CSPEED: cspeed_reg <= pwdata[SPEED_W-1:0];
                A_VARG: varg_reg <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_reg <= 1'b0;
        end else if (start_cmd) begin
            refused_reg <= !start_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Search sequencer: optional far switch, seek, creep off, re-enter, optional pass through.
    wire act = pick_sw(sw, plan_reg.sw_sel, plan_reg.home_inv);
    wire far_act = pick_sw(sw, (plan_reg.sw_sel == SEL_LEFT) ? SEL_RIGHT : SEL_LEFT, 1'b0);

    always_comb begin
        state_next = state_reg;
        run_dir_next = run_dir_reg;
        if (stop_cmd) begin
            state_next = S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: if (start_ok) begin
                    state_next = smode_plan.far_first ? S_FAR : S_SEEK;
                    run_dir_next = smode_plan.far_first ? !smode_plan.pos_dir
                                                        : smode_plan.pos_dir;
                end
                S_FAR: if (far_act) begin
                    state_next = S_SEEK;
                    run_dir_next = plan_reg.pos_dir;
                end
                S_SEEK: begin
                    if (act) begin
                        state_next = S_CLEAR;
                        run_dir_next = !run_dir_reg;
                    end else if (plan_reg.rev_lim == SEL_LEFT && sw.left && !run_dir_reg) begin
                        run_dir_next = 1'b1;
                    end else if (plan_reg.rev_lim == SEL_RIGHT && sw.right && run_dir_reg) begin
                        run_dir_next = 1'b0;
                    end
                end
                S_CLEAR: if (!act) begin
                    state_next = S_ENTER;
                    run_dir_next = !run_dir_reg;
                end
                S_ENTER: if (act) begin
                    state_next = plan_reg.middle ? S_THRU : S_DONE;
                end
                S_THRU: if (!act) begin
                    state_next = S_DONE;
                end
                S_DONE: state_next = S_IDLE;
                default: state_next = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            run_dir_reg <= 1'b0;
            plan_reg <= '0;
            vel_out <= '0;
            dir_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            run_dir_reg <= run_dir_next;
            dir_out <= run_dir_next;
            if (state_reg == S_IDLE && start_ok) begin
                plan_reg <= smode_plan;
            end
            if (state_next == S_FAR || state_next == S_SEEK) begin
                vel_out <= sspeed_reg;
            end else if (state_next == S_CLEAR || state_next == S_ENTER || state_next == S_THRU) begin
                vel_out <= cspeed_reg;
            end else begin
                vel_out <= '0;
            end
        end
    end

    // Switching points; positions are latched on the cycle the switch level changes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {far_pos_reg, e1_reg, e2_reg, e3_reg} <= '0;
        end else begin
            if (state_reg == S_FAR && far_act) far_pos_reg <= pos_reg;
            if (state_reg == S_CLEAR && !act) e1_reg <= pos_reg;
            if (state_reg == S_ENTER && act) e2_reg <= pos_reg;
            if (state_reg == S_THRU && !act) e3_reg <= pos_reg;
        end
    end

    // A step still in flight during the completion cycle is counted, or the counter would trail the stage.
    wire [31:0] step_delta = !step_tick ? 32'h0000_0000 : dir_out ? 32'h0000_0001 : 32'hFFFF_FFFF;

    // The sum takes 33 bits so the midpoint of two far positions does not wrap.
    logic [32:0] mid_sum;
    logic [31:0] far_dist;
    always_comb begin
        mid_sum = plan_reg.middle ? ({e2_reg[31], e2_reg} + {e3_reg[31], e3_reg})
                                  : ({e1_reg[31], e1_reg} + {e2_reg[31], e2_reg});
        ref_pos = mid_sum[32:1];
        far_dist = ($signed(far_pos_reg) > $signed(ref_pos)) ? far_pos_reg - ref_pos : ref_pos - far_pos_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_reg <= 32'h0000_0000;
            dist_reg <= 32'h0000_0000;
        end else if (state_reg == S_DONE) begin
            pos_reg <= pos_reg - ref_pos + step_delta;
            if (plan_reg.far_first) dist_reg <= far_dist;
        end else begin
            pos_reg <= pos_reg + step_delta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // User variables. The nonvolatile copy has no reset so it survives presetn like storage would.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_busy_reg <= 1'b1;
            boot_idx_reg <= 8'h00;
        end else if (boot_busy_reg) begin
            boot_idx_reg <= boot_idx_reg + 8'h01;
            if (boot_idx_reg == UV_NV_LAST) boot_busy_reg <= 1'b0;
        end
    end

    wire nv_ok = vidx <= UV_NV_LAST;
    always_ff @(posedge pclk) begin
        if (boot_busy_reg) begin
            uv_ram[boot_idx_reg] <= uv_nv[boot_idx_reg[5:0]];
        end else if (vcmd_wr) begin
            unique case (vop)
                VOP_SET: uv_ram[vidx] <= varg_reg;
                VOP_ADD: uv_ram[vidx] <= uv_ram[vidx] + varg_reg;
                VOP_SUB: uv_ram[vidx] <= uv_ram[vidx] - varg_reg;
                VOP_RESTORE: if (nv_ok) uv_ram[vidx] <= uv_nv[vidx[5:0]];
                default: ;
            endcase
        end
        if (vcmd_wr && vop == VOP_STORE && nv_ok) begin
            uv_nv[vidx[5:0]] <= uv_ram[vidx];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vrd_reg <= 32'h0000_0000;
            var_err_reg <= 1'b0;
        end else if (vcmd_wr) begin
            if (vop == VOP_READ) vrd_reg <= uv_ram[vidx];
            var_err_reg <= ((vop == VOP_STORE || vop == VOP_RESTORE) && !nv_ok) || vop > VOP_RESTORE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Zero-wait slave; reads are combinational from registers and inputs, unmapped addresses answer an error.
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            A_CFG: prdata[3:0] = {stop_right_en_reg, stop_left_en_reg, imode_reg};
            A_SMODE: prdata[7:0] = smode_reg;
            A_SSPEED: prdata[SPEED_W-1:0] = sspeed_reg;
            A_CSPEED: prdata[SPEED_W-1:0] = cspeed_reg;
            A_DIST: prdata = dist_reg;
            A_POS: prdata = pos_reg;
            A_CMD: prdata = 32'h0000_0000;
            A_STATUS: prdata[10:0] = {state_reg, var_err_reg, boot_busy_reg, refused_reg, search_busy};
            A_DIN: prdata[2:0] = {general_input_three, general_input_two,
                                  general_input_one && imode_reg != IMODE_FREE};
            A_AIN: prdata[AIN_W-1:0] = (imode_reg == IMODE_FREE) ? ain_value : '0;
            A_VCMD: prdata = 32'h0000_0000;
            A_VARG: prdata = varg_reg;
            A_VRD: prdata = vrd_reg;
            default: pslverr = psel && penable;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_start_ref_only: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(search_busy) |-> $past(imode_reg) == IMODE_REF) else $error("search started outside reference mode");
    a_seek_speed: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_SEEK && !$rose(state_reg == S_SEEK) |-> vel_out == sspeed_reg) else $error("seek speed wrong");
    a_calib_speed: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == S_CLEAR || state_reg == S_ENTER) |-> vel_out == cspeed_reg) else $error("calibration speed wrong");
    a_done_stops: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_DONE |=> state_reg == S_IDLE && vel_out == '0
            && pos_reg == $past(pos_reg) - $past(ref_pos) + $past(step_delta))
        else $error("completion did not zero and stop");
    a_end_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
        search_busy |-> !end_stop) else $error("end stop active during search");
    a_enc_map: assert property (@(posedge pclk) disable iff (!presetn)
        imode_reg == IMODE_ENC |-> enc_a == general_input_two && enc_b == general_input_three && !sw.left)
        else $error("encoder mapping wrong");
    a_free_din: assert property (@(posedge pclk) disable iff (!presetn)
        paddr == A_DIN && imode_reg == IMODE_FREE |-> prdata[0] == 1'b0) else $error("analog input on digital bank");
    a_boot_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(boot_busy_reg) |-> $past(boot_idx_reg) == UV_NV_LAST) else $error("boot copy length wrong");
    a_nv_range: assert property (@(posedge pclk) disable iff (!presetn)
        vcmd_wr && vop == VOP_STORE && vidx > UV_NV_LAST |=> var_err_reg) else $error("store beyond range accepted");
    a_stop_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        stop_cmd |=> state_reg == S_IDLE ##1 vel_out == '0 || state_reg != S_IDLE) else $error("stop ignored");
    a_thru_speed: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_THRU |-> vel_out == cspeed_reg) else $error("pass-through speed wrong");
    a_refuse_mode: assert property (@(posedge pclk) disable iff (!presetn)
        start_cmd && imode_reg != IMODE_REF |=> refused_reg) else $error("start outside reference mode accepted");
    a_left_rev: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_SEEK && plan_reg.rev_lim == SEL_LEFT && sw.left && !run_dir_reg && !act && !stop_cmd
        |=> run_dir_reg) else $error("no reversal at left limit");
    a_right_rev: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == S_SEEK && plan_reg.rev_lim == SEL_RIGHT && sw.right && run_dir_reg && !act && !stop_cmd
        |=> !run_dir_reg) else $error("no reversal at right limit");
    a_ref_map: assert property (@(posedge pclk) disable iff (!presetn)
        imode_reg == IMODE_REF |-> sw == {general_input_one, general_input_two, general_input_three})
        else $error("reference switch mapping wrong");
    a_free_map: assert property (@(posedge pclk) disable iff (!presetn)
        imode_reg == IMODE_FREE |-> sw == '0 && !enc_a && !enc_b) else $error("free inputs not released");
    a_ain_bank: assert property (@(posedge pclk) disable iff (!presetn)
        paddr == A_AIN && imode_reg != IMODE_FREE |-> prdata == 32'h0000_0000) else $error("analog bank not empty");
endmodule : hsm_homing

// File: testbench/hsm_stage.sv
// Motor stage model: counts microsteps and shows home, left and right switch windows.
`timescale 1ns/1ps
module hsm_stage
    import hsm_pkg::*;
#(
    parameter int L_LO = -60,
    parameter int L_HI = -40,
    parameter int R_LO = 40,
    parameter int R_HI = 60,
    parameter int H_LO = 20,
    parameter int H_HI = 30
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [SPEED_W-1:0] vel_out,
    input wire logic dir_out,
    input wire logic home_low,
    output logic step_tick,
    output hsm_sw_t sw,
    output int pos
);
    logic ph;
    int p = 0;
    // A step comes every other cycle, so a switch change is seen before the next step.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 1'b0;
            step_tick <= 1'b0;
        end else begin
            ph <= ~ph;
            step_tick <= ph && (vel_out != '0);
        end
    end
    // The slider keeps its place through a reset, as a real stage does.
    always_ff @(posedge pclk) begin
        if (step_tick) begin
            p <= dir_out ? p + 1 : p - 1;
        end
    end
    assign pos = p;
    // A normally closed home switch is modelled by home_low.
    assign sw.home = ((p >= H_LO) && (p <= H_HI)) ^ home_low;
    assign sw.left = (p >= L_LO) && (p <= L_HI);
    assign sw.right = (p >= R_LO) && (p <= R_HI);
endmodule : hsm_stage

// File: testbench/homing_search_and_input_mode_tb.sv
// Self-checking bench for the homing search and input mode block.
`timescale 1ns/1ps
module homing_search_and_input_mode_tb;
    import hsm_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pready, pslverr, rerr, enc_a, enc_b, dir_out, end_stop, search_busy, step_tick;
    logic ovr = 1'b0, hinv = 1'b0;
    logic [2:0] ovin = 3'h0;
    logic [AIN_W-1:0] ain_value = '0;
    logic [SPEED_W-1:0] vel_out, ss, cs;
    hsm_sw_t sw;
    int pos, miscompares = 0, check_count = 0, seed = 32'h0000_22f8, uv[256], nv[56];
    initial forever #12.5 pclk = ~pclk;
    hsm_homing dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_input_one(ovr ? ovin[0] : sw.home), .general_input_two(ovr ? ovin[1] : sw.left),
        .general_input_three(ovr ? ovin[2] : sw.right), .ain_value(ain_value), .step_tick(step_tick),
        .enc_a(enc_a), .enc_b(enc_b), .vel_out(vel_out), .dir_out(dir_out), .end_stop(end_stop),
        .search_busy(search_busy));
    hsm_stage stage_u (.pclk(pclk), .presetn(presetn), .vel_out(vel_out), .dir_out(dir_out),
        .home_low(hinv), .step_tick(step_tick), .sw(sw), .pos(pos));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic vop(input logic [2:0] op, input logic [7:0] idx, input logic [31:0] arg);
        apb(1'b1, A_VARG, arg);
        apb(1'b1, A_VCMD, {21'h0, op, idx});
    endtask : vop
    task automatic vget(input logic [7:0] idx, input int exp);
        vop(VOP_READ, idx, 32'h0);
        apb(1'b0, A_VRD, 32'h0);
        chk(rdat, exp);
    endtask : vget
    task automatic boot_wait;
        int n;
        n = 0;
        do begin
            apb(1'b0, A_STATUS, 32'h0);
            n++;
        end while (rdat[2] !== 1'b0 && n < 100);
        chk({31'h0, rdat[2]}, 32'h0);
    endtask : boot_wait
    // The reference is judged in stage coordinates; two steps of slack cover midpoint rounding.
    task automatic search(input logic [7:0] mode, input int exp_ref);
        int n;
        logic [SPEED_W-1:0] first, last;
        first = '0;
        last = '0;
        apb(1'b1, A_SMODE, {24'h0, mode});
        apb(1'b1, A_CMD, {16'h0, RFS_START, OPC_REF_SEARCH});
        for (n = 0; n < 20000; n++) begin
            @(posedge pclk);
            if (vel_out != '0 && first == '0) first = vel_out;
            if (vel_out != '0) last = vel_out;
            if (search_busy === 1'b1) chk({31'h0, end_stop}, 32'h0);
            if (search_busy !== 1'b1 && n > 2) break;
        end
        chk({8'h0, first}, {8'h0, ss});
        chk({8'h0, last}, {8'h0, cs});
        chk({8'h0, vel_out}, 32'h0);
        apb(1'b0, A_POS, 32'h0);
        chk({31'h0, (pos - $signed(rdat) - exp_ref) inside {[-2:2]}}, 32'h1);
        apb(1'b0, A_STATUS, 32'h0);
        chk(rdat & 32'h0000_07F1, 32'h0000_0010);
    endtask : search
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ss = 24'h01_0000 | SPEED_W'($random(seed));
        cs = {16'h0, 8'($random(seed))} | 24'h00_0001;
        apb(1'b0, A_SMODE, 32'h0);
        chk(rdat, {24'h0, SMODE_RST});
        apb(1'b0, A_CFG, 32'h0);
        chk(rdat, {28'h0, CFG_RST});
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, A_CFG, 32'(m));
            ovr <= 1'b1;
            ovin <= 3'($random(seed));
            ain_value <= AIN_W'($random(seed));
            repeat (4) @(posedge pclk);
            apb(1'b0, A_DIN, 32'h0);
            chk(rdat, {29'h0, ovin[2:1], ovin[0] & (m != 2)});
            apb(1'b0, A_AIN, 32'h0);
            chk(rdat, (m == 2) ? {22'h0, ain_value} : 32'h0);
            chk({30'h0, enc_a, enc_b}, (m == 1) ? {30'h0, ovin[1], ovin[2]} : 32'h0);
        end
        ovr <= 1'b0;
        apb(1'b1, A_CMD, {16'h0, RFS_START, OPC_REF_SEARCH});
        apb(1'b0, A_STATUS, 32'h0);
        chk(rdat & 32'h0000_0003, 32'h0000_0002);
        apb(1'b1, A_CFG, 32'h0000_000C);
        apb(1'b1, A_SSPEED, {8'h0, ss});
        apb(1'b1, A_CSPEED, {8'h0, cs});
        search(8'd5, 25);
        search(8'd1, -40);
        chk({31'h0, end_stop}, 32'h1);
        search(8'd65, 40);
        search(8'd6, 25);
        hinv <= 1'b1;
        search(8'd135, 25);
        hinv <= 1'b0;
        search(8'd8, 25);
        search(8'd66, 40);
        apb(1'b0, A_DIST, 32'h0);
        chk({31'h0, ($signed(rdat) - 80) inside {[-2:2]}}, 32'h1);
        search(8'd4, -50);
        search(8'd3, -50);
        apb(1'b0, A_DIST, 32'h0);
        chk({31'h0, ($signed(rdat) - 90) inside {[-2:2]}}, 32'h1);
        apb(1'b1, A_SMODE, 32'h0000_0004);
        apb(1'b1, A_CMD, {16'h0, RFS_START, OPC_REF_SEARCH});
        repeat (10) @(posedge pclk);
        chk({31'h0, search_busy}, 32'h1);
        apb(1'b1, A_CMD, {16'h0, RFS_STOP, OPC_REF_SEARCH});
        apb(1'b0, A_STATUS, 32'h0);
        chk(rdat & 32'h0000_07F1, 32'h0000_0010);
        chk({8'h0, vel_out}, 32'h0);
        boot_wait();
        uv[5] = $random(seed);
        vop(VOP_SET, 8'd5, uv[5]);
        nv[0] = $random(seed);
        vop(VOP_ADD, 8'd5, nv[0]);
        uv[5] += nv[0];
        nv[0] = $random(seed);
        vop(VOP_SUB, 8'd5, nv[0]);
        uv[5] -= nv[0];
        vget(8'd5, uv[5]);
        vop(VOP_STORE, 8'd5, 32'h0);
        nv[5] = uv[5];
        uv[255] = $random(seed);
        vop(VOP_SET, 8'd255, uv[255]);
        vget(8'd255, uv[255]);
        vop(VOP_STORE, 8'd56, 32'h0);
        apb(1'b0, A_STATUS, 32'h0);
        chk({31'h0, rdat[3]}, 32'h1);
        vop(VOP_SET, 8'd5, 32'h0);
        vop(VOP_RESTORE, 8'd5, 32'h0);
        vget(8'd5, nv[5]);
        vop(VOP_SET, 8'd5, 32'h0000_0007);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        boot_wait();
        vget(8'd5, nv[5]);
        give_verdict();
    end
endmodule : homing_search_and_input_mode_tb
